// file: imod_cfg.svh
// Offsets, field codes, reset values and timing figures of the output data bank.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef IMOD_CFG_SVH
`define IMOD_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses on the serial port)
`define IMOD_OFS_ACCEL_Y_LOW   8'h14
`define IMOD_OFS_ACCEL_Y_HIGH  8'h16
`define IMOD_OFS_ACCEL_Z_LOW   8'h18
`define IMOD_OFS_ACCEL_Z_HIGH  8'h1a
`define IMOD_OFS_TEMP          8'h1c
`define IMOD_OFS_STAMP         8'h1e
`define IMOD_OFS_COUNTER       8'h22
`define IMOD_OFS_DANG_X_LOW    8'h24
`define IMOD_OFS_DANG_X_HIGH   8'h26
`define IMOD_OFS_DANG_Y_LOW    8'h28
`define IMOD_OFS_DANG_Y_HIGH   8'h2a
`define IMOD_OFS_DANG_Z_LOW    8'h2c
`define IMOD_OFS_DANG_Z_HIGH   8'h2e

// ==========================================================================
// Fields and reset values
`define IMOD_SYNC_INTERNAL     3'b000
`define IMOD_SYNC_SCALED       3'b010
`define IMOD_WORD_RST          16'h0000
`define IMOD_COUNTER_RST       16'h0000
`define IMOD_UNMAPPED_WORD     16'h0000
`define IMOD_FRAME_LAST_BIT    4'hf

// Delta-angle scaling shifts for the three range variants
`define IMOD_DA_SHIFT_R360     6'h00
`define IMOD_DA_SHIFT_R720     6'h01
`define IMOD_DA_SHIFT_R2160    6'h02

// ==========================================================================
// Timing
`define IMOD_CLK_PERIOD_PS     10000
`define IMOD_SAMPLE_PERIOD_PS  500000000
`define IMOD_STAMP_STEP_PS     49020000

`endif

// file: imod_pkg.sv
// Types shared by the output data bank modules.
// Numeric constants live in imod_cfg.svh.
package imod_pkg;

   // ==========================================================================
   // Register selection
   typedef enum logic [3:0] {
      IMOD_SEL_AYL  = 4'h0,
      IMOD_SEL_AYH  = 4'h1,
      IMOD_SEL_AZL  = 4'h2,
      IMOD_SEL_AZH  = 4'h3,
      IMOD_SEL_TMP  = 4'h4,
      IMOD_SEL_STP  = 4'h5,
      IMOD_SEL_CNT  = 4'h6,
      IMOD_SEL_DXL  = 4'h7,
      IMOD_SEL_DXH  = 4'h8,
      IMOD_SEL_DYL  = 4'h9,
      IMOD_SEL_DYH  = 4'ha,
      IMOD_SEL_DZL  = 4'hb,
      IMOD_SEL_DZH  = 4'hc,
      IMOD_SEL_NONE = 4'hf
   } imod_sel_t;

   // ==========================================================================
   // Gyroscope range variant
   typedef enum logic [1:0] {
      IMOD_RANGE_360  = 2'b00,
      IMOD_RANGE_720  = 2'b01,
      IMOD_RANGE_2160 = 2'b10
   } imod_range_t;

endpackage

// file: imod_stamp.sv
// Sync pin conditioning and sync-relative time base.
// Assumes sync_pin is asynchronous to clk; stamp_now counts steps since the last rising edge.
`timescale 1ns/1ps
`include "imod_cfg.svh"

module imod_stamp #(
   parameter int STAMP_CYCLES = `IMOD_STAMP_STEP_PS / `IMOD_CLK_PERIOD_PS
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        sync_pin,
   output logic             sync_edge,
   output logic [15:0]      stamp_now
);

   logic [2:0]  sync_sh_q;
   logic        sync_lvl_q;
   logic [15:0] step_cnt_q;
   logic [15:0] stamp_q;
   logic        step_end;

   // ==========================================================================
   // Pin synchroniser; level accepted once stages two and three agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_sh_q  <= 3'h0;
         sync_lvl_q <= 1'b0;
      end else begin
         sync_sh_q <= {sync_sh_q[1:0], sync_pin};
         if (sync_sh_q[1] == sync_sh_q[2]) begin
            sync_lvl_q <= sync_sh_q[2];
         end
      end
   end

   assign sync_edge = (sync_sh_q[1] == sync_sh_q[2]) && sync_sh_q[2] && !sync_lvl_q;

   // ==========================================================================
   // Step timer and elapsed count, both restarted by each sync edge
   assign step_end = (step_cnt_q == 16'(STAMP_CYCLES - 1));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         step_cnt_q <= 16'h0000;
      end else if (sync_edge || step_end) begin
         step_cnt_q <= 16'h0000;
      end else begin
         step_cnt_q <= step_cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stamp_q <= `IMOD_WORD_RST;
      end else if (sync_edge) begin
         stamp_q <= `IMOD_WORD_RST;
      end else if (step_end && stamp_q != 16'hffff) begin
         // Saturates rather than wrapping if sync stops
         stamp_q <= stamp_q + 16'h0001;
      end
   end

   assign stamp_now = stamp_q;

endmodule

// file: imod_out_regs.sv
// Output data bank: acceleration, temperature, time stamp, update counter, delta angles.
// Assumes sensor samples arrive on clk; the host reads over a 16-bit serial frame port on sclk.
`timescale 1ns/1ps
`include "imod_cfg.svh"

module imod_out_regs #(
   parameter int                   SAMPLE_CYCLES = `IMOD_SAMPLE_PERIOD_PS / `IMOD_CLK_PERIOD_PS,
   parameter int                   STAMP_CYCLES  = `IMOD_STAMP_STEP_PS / `IMOD_CLK_PERIOD_PS,
   parameter imod_pkg::imod_range_t RANGE        = imod_pkg::IMOD_RANGE_360
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [31:0] accel_y_sample,
   input  wire logic [31:0] accel_z_sample,
   input  wire logic [15:0] temp_sample,
   input  wire logic [31:0] gyro_x_sample,
   input  wire logic [31:0] gyro_y_sample,
   input  wire logic [31:0] gyro_z_sample,
   input  wire logic        ext_sample_tick,
   input  wire logic [2:0]  sync_mode,
   input  wire logic [15:0] decimation_setting,
   input  wire logic        reset_cmd,
   input  wire logic        sync_pin,
   output logic             sample_tick,
   output logic             sample_ready_output,
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        sdi,
   output logic             sdo,
   output logic             sdo_oe
);

   // ==========================================================================
   // Declarations
   logic [31:0] accel_y_q;
   logic [31:0] accel_z_q;
   logic [15:0] temp_q;
   logic [15:0] stamp_q;
   logic [15:0] counter_q;
   logic [31:0] dang_q [3];
   logic [31:0] gyro_in [3];
   logic [15:0] dec_cnt_q;
   logic [31:0] div_cnt_q;
   logic        int_tick;
   logic        last_sample;
   logic        update;
   logic        ready_q;
   logic        sync_edge;
   logic [15:0] stamp_now;
   logic [5:0]  da_shift;
   logic [3:0]  bit_cnt_q;
   logic [15:0] rx_q;
   logic [7:0]  addr_lq;
   logic        req_lq;
   logic        sdo_q;
   logic [2:0]  req_sh_q;
   logic        req_seen_q;
   logic        req_event;
   logic [15:0] reply_q;

   assign gyro_in[0] = gyro_x_sample;
   assign gyro_in[1] = gyro_y_sample;
   assign gyro_in[2] = gyro_z_sample;

   // ==========================================================================
   // Address decode
   function automatic imod_pkg::imod_sel_t sel_of(input logic [7:0] a);
      case (a)
         `IMOD_OFS_ACCEL_Y_LOW:  sel_of = imod_pkg::IMOD_SEL_AYL;
         `IMOD_OFS_ACCEL_Y_HIGH: sel_of = imod_pkg::IMOD_SEL_AYH;
         `IMOD_OFS_ACCEL_Z_LOW:  sel_of = imod_pkg::IMOD_SEL_AZL;
         `IMOD_OFS_ACCEL_Z_HIGH: sel_of = imod_pkg::IMOD_SEL_AZH;
         `IMOD_OFS_TEMP:         sel_of = imod_pkg::IMOD_SEL_TMP;
         `IMOD_OFS_STAMP:        sel_of = imod_pkg::IMOD_SEL_STP;
         `IMOD_OFS_COUNTER:      sel_of = imod_pkg::IMOD_SEL_CNT;
         `IMOD_OFS_DANG_X_LOW:   sel_of = imod_pkg::IMOD_SEL_DXL;
         `IMOD_OFS_DANG_X_HIGH:  sel_of = imod_pkg::IMOD_SEL_DXH;
         `IMOD_OFS_DANG_Y_LOW:   sel_of = imod_pkg::IMOD_SEL_DYL;
         `IMOD_OFS_DANG_Y_HIGH:  sel_of = imod_pkg::IMOD_SEL_DYH;
         `IMOD_OFS_DANG_Z_LOW:   sel_of = imod_pkg::IMOD_SEL_DZL;
         `IMOD_OFS_DANG_Z_HIGH:  sel_of = imod_pkg::IMOD_SEL_DZH;
         default:                sel_of = imod_pkg::IMOD_SEL_NONE;
      endcase
   endfunction

   // ==========================================================================
   // Sample timing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_cnt_q <= 32'h0000_0000;
      end else if (div_cnt_q == 32'(SAMPLE_CYCLES - 1)) begin
         div_cnt_q <= 32'h0000_0000;
      end else begin
         div_cnt_q <= div_cnt_q + 32'h0000_0001;
      end
   end

   assign int_tick    = (div_cnt_q == 32'(SAMPLE_CYCLES - 1));
   // Internal clock unless an external sample source is selected
   assign sample_tick = (sync_mode == `IMOD_SYNC_INTERNAL) ? int_tick : ext_sample_tick;
   assign last_sample = (dec_cnt_q >= decimation_setting);
   assign update      = sample_tick && last_sample;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dec_cnt_q <= 16'h0000;
      end else if (reset_cmd) begin
         dec_cnt_q <= 16'h0000;
      end else if (sample_tick) begin
         // Setting plus one samples per output period
         dec_cnt_q <= last_sample ? 16'h0000 : dec_cnt_q + 16'h0001;
      end
   end

   // ==========================================================================
   // Time base
   imod_stamp #(
      .STAMP_CYCLES (STAMP_CYCLES)
   ) u_stamp (
      .clk       (clk),
      .rst       (rst),
      .sync_pin  (sync_pin),
      .sync_edge (sync_edge),
      .stamp_now (stamp_now)
   );

   // ==========================================================================
   // Delta-angle integrators
   always_comb begin
      case (RANGE)
         imod_pkg::IMOD_RANGE_360:  da_shift = `IMOD_DA_SHIFT_R360;
         imod_pkg::IMOD_RANGE_720:  da_shift = `IMOD_DA_SHIFT_R720;
         imod_pkg::IMOD_RANGE_2160: da_shift = `IMOD_DA_SHIFT_R2160;
         default:                   da_shift = `IMOD_DA_SHIFT_R360;
      endcase
   end

   for (genvar i = 0; i < 3; i++) begin : g_axis
      logic signed [47:0] acc_q;
      logic signed [31:0] prev_q;
      logic signed [47:0] pair;
      logic signed [47:0] total;
      logic signed [47:0] scaled;

      assign pair   = 48'(signed'(gyro_in[i])) + 48'(prev_q);
      assign total  = acc_q + pair;
      // Halving is the 1/(2 fs) term; rate is taken per sample period
      assign scaled = total >>> (da_shift + 6'h01);

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            acc_q  <= 48'sh0;
            prev_q <= 32'sh0;
         end else begin
            // Previous rate survives a reset command, so the next pair is two real samples
            if (sample_tick) begin
               prev_q <= signed'(gyro_in[i]);
            end
            if (reset_cmd) begin
               acc_q <= 48'sh0;
            end else if (sample_tick) begin
               acc_q <= last_sample ? 48'sh0 : total;
            end
         end
      end

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            dang_q[i] <= 32'h0000_0000;
         end else if (update) begin
            // High half is twos complement, full scale over 2^15
            dang_q[i] <= scaled[31:0];
         end
      end
   end

   // ==========================================================================
   // Coherent output load
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         accel_y_q <= 32'h0000_0000;
         accel_z_q <= 32'h0000_0000;
         temp_q    <= `IMOD_WORD_RST;
         stamp_q   <= `IMOD_WORD_RST;
      end else if (update) begin
         accel_y_q <= accel_y_sample;
         accel_z_q <= accel_z_sample;
         temp_q    <= temp_sample;
         // Stamp of the final sample; zero outside scaled sync
         stamp_q   <= (sync_mode == `IMOD_SYNC_SCALED) ? stamp_now : `IMOD_WORD_RST;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         counter_q <= `IMOD_COUNTER_RST;
      end else if (reset_cmd) begin
         counter_q <= `IMOD_COUNTER_RST;
      end else if (update) begin
         counter_q <= counter_q + 16'h0001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= update && !reset_cmd;
      end
   end

   assign sample_ready_output = ready_q;

   // ==========================================================================
   // Serial frame port, link clock side
   always_ff @(posedge sclk or posedge rst or posedge cs_n) begin
      if (rst) begin
         bit_cnt_q <= 4'h0;
      end else if (cs_n) begin
         bit_cnt_q <= 4'h0;
      end else begin
         bit_cnt_q <= bit_cnt_q + 4'h1;
      end
   end

   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         rx_q    <= 16'h0000;
         addr_lq <= 8'h00;
         req_lq  <= 1'b0;
      end else if (!cs_n) begin
         rx_q <= {rx_q[14:0], sdi};
         // Writes are ignored: every word here is read-only
         if (bit_cnt_q == `IMOD_FRAME_LAST_BIT && !rx_q[14]) begin
            addr_lq <= {1'b0, rx_q[13:7]};
            req_lq  <= !req_lq;
         end
      end
   end

   // Reply word is stable long before the next frame starts
   always_ff @(negedge sclk or posedge rst) begin
      if (rst) begin
         sdo_q <= 1'b0;
      end else begin
         sdo_q <= reply_q[`IMOD_FRAME_LAST_BIT - bit_cnt_q];
      end
   end

   assign sdo    = sdo_q;
   assign sdo_oe = !cs_n;

   // ==========================================================================
   // Serial frame port, system clock side
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_sh_q   <= 3'h0;
         req_seen_q <= 1'b0;
      end else begin
         req_sh_q <= {req_sh_q[1:0], req_lq};
         if (req_event) begin
            req_seen_q <= req_sh_q[2];
         end
      end
   end

   assign req_event = (req_sh_q[1] == req_sh_q[2]) && (req_sh_q[2] != req_seen_q);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reply_q <= `IMOD_UNMAPPED_WORD;
      end else if (req_event) begin
         case (sel_of(addr_lq))
            imod_pkg::IMOD_SEL_AYL: reply_q <= accel_y_q[15:0];
            imod_pkg::IMOD_SEL_AYH: reply_q <= accel_y_q[31:16];
            imod_pkg::IMOD_SEL_AZL: reply_q <= accel_z_q[15:0];
            imod_pkg::IMOD_SEL_AZH: reply_q <= accel_z_q[31:16];
            imod_pkg::IMOD_SEL_TMP: reply_q <= temp_q;
            imod_pkg::IMOD_SEL_STP: reply_q <= stamp_q;
            imod_pkg::IMOD_SEL_CNT: reply_q <= counter_q;
            imod_pkg::IMOD_SEL_DXL: reply_q <= dang_q[0][15:0];
            imod_pkg::IMOD_SEL_DXH: reply_q <= dang_q[0][31:16];
            imod_pkg::IMOD_SEL_DYL: reply_q <= dang_q[1][15:0];
            imod_pkg::IMOD_SEL_DYH: reply_q <= dang_q[1][31:16];
            imod_pkg::IMOD_SEL_DZL: reply_q <= dang_q[2][15:0];
            imod_pkg::IMOD_SEL_DZH: reply_q <= dang_q[2][31:16];
            default:                reply_q <= `IMOD_UNMAPPED_WORD;
         endcase
      end
   end

endmodule

// file: imod_out_regs_checker.sv
// Port checks for the output data bank.
// Assumes binding onto imod_out_regs; all checks sample on clk.
`timescale 1ns/1ps
module imod_out_regs_checker #(
   parameter int SAMPLE_CYCLES = 20
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        ext_sample_tick,
   input wire logic [2:0]  sync_mode,
   input wire logic [15:0] decimation_setting,
   input wire logic        reset_cmd,
   input wire logic        sample_tick,
   input wire logic        sample_ready_output,
   input wire logic        sdo
);
   logic [16:0] tick_q;
   logic [31:0] gap_q;
   logic        int_ok_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ====
   // Helpers: ticks per update, gap between internal ticks
   always_ff @(posedge clk or posedge rst) begin
      if (rst || reset_cmd) begin
         tick_q <= 17'h0;
      end else if (sample_ready_output) begin
         tick_q <= {16'h0, sample_tick};
      end else begin
         tick_q <= tick_q + {16'h0, sample_tick};
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst || sample_tick) begin
         gap_q <= 32'h0;
      end else begin
         gap_q <= gap_q + 32'h1;
      end
   end
   // Only trusted once an internal tick has been seen
   always_ff @(posedge clk or posedge rst) begin
      if (rst || sync_mode != 3'h0) begin
         int_ok_q <= 1'b0;
      end else if (sample_tick) begin
         int_ok_q <= 1'b1;
      end
   end
   // ====
   // Assertions
   property p_ready_single;
      (sample_ready_output && !sample_tick) |=> !sample_ready_output;
   endproperty
   a_ready_single: assert property (p_ready_single)
      else $error("ready pulse too long");
   property p_ready_cause;
      sample_ready_output |-> $past(sample_tick) && !$past(reset_cmd);
   endproperty
   a_ready_cause: assert property (p_ready_cause)
      else $error("ready without tick");
   property p_dec_len;
      sample_ready_output |-> tick_q == {1'b0, decimation_setting} + 17'h1;
   endproperty
   a_dec_len: assert property (p_dec_len)
      else $error("wrong ticks per update");
   property p_dec_zero;
      (sample_tick && decimation_setting == 16'h0 && !reset_cmd) |=> sample_ready_output;
   endproperty
   a_dec_zero: assert property (p_dec_zero)
      else $error("no update at setting zero");
   property p_ext_tick;
      sync_mode != 3'h0 |-> sample_tick == ext_sample_tick;
   endproperty
   a_ext_tick: assert property (p_ext_tick)
      else $error("wrong sample strobe");
   property p_int_period;
      (sync_mode == 3'h0 && int_ok_q) |->
         gap_q < SAMPLE_CYCLES && (!sample_tick || gap_q == SAMPLE_CYCLES - 1);
   endproperty
   a_int_period: assert property (p_int_period)
      else $error("internal tick period wrong");
   property p_cmd_wins;
      reset_cmd |=> !sample_ready_output;
   endproperty
   a_cmd_wins: assert property (p_cmd_wins)
      else $error("update beat reset command");
   property p_rst_quiet;
      $fell(rst) |-> !sample_ready_output && !sdo;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("outputs not clear after reset");
endmodule

bind imod_out_regs imod_out_regs_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
   .clk(clk), .rst(rst), .ext_sample_tick(ext_sample_tick), .sync_mode(sync_mode),
   .decimation_setting(decimation_setting), .reset_cmd(reset_cmd),
   .sample_tick(sample_tick), .sample_ready_output(sample_ready_output), .sdo(sdo));

// file: imod_host.sv
// Host model: serial link master, idle-high clock, 16-bit frames.
// Assumes the device samples sdi on rising sclk and shifts sdo on falling sclk.
`timescale 1ns/1ps
module imod_host (
   output logic     sclk,
   output logic     cs_n,
   output logic     sdi,
   input wire logic sdo
);
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      sdi  = 1'b1;
   end
   // ====
   // One bit every 30 ns; clock stands still between frames
   task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
      cs_n = 1'b0;
      #15;
      for (int i = 15; i >= 0; i--) begin
         sclk = 1'b0;
         sdi  = cmd[i];
         #15 sclk = 1'b1;
         rsp[i] = sdo;
         #15;
      end
      cs_n = 1'b1;
      // Released line shows the inverse, not a stale bit
      sdi = ~sdi;
      // Gap lets the reply load before the next frame
      #120;
   endtask
endmodule

// file: imod_out_regs_tb.sv
// Testbench for the output data bank, register reads over the serial link.
// Assumes imod_host as link master and the bound port checker.
`timescale 1ns/1ps
`include "imod_cfg.svh"
module imod_out_regs_tb;
   logic        clk, rst, ext_sample_tick, reset_cmd, sync_pin;
   logic        sample_tick, sample_ready_output, sclk, cs_n, sdi, sdo, sdo_oe;
   logic [31:0] accel_y_sample, accel_z_sample, gyro_x_sample, gyro_y_sample;
   logic [31:0] gyro_z_sample, da;
   logic [15:0] temp_sample, decimation_setting, v;
   logic [2:0]  sync_mode;
   int          err_total, tests_run;

   imod_out_regs #(.SAMPLE_CYCLES(20), .STAMP_CYCLES(3)) dut (
      .clk(clk), .rst(rst), .accel_y_sample(accel_y_sample),
      .accel_z_sample(accel_z_sample), .temp_sample(temp_sample),
      .gyro_x_sample(gyro_x_sample), .gyro_y_sample(gyro_y_sample),
      .gyro_z_sample(gyro_z_sample), .ext_sample_tick(ext_sample_tick),
      .sync_mode(sync_mode), .decimation_setting(decimation_setting),
      .reset_cmd(reset_cmd), .sync_pin(sync_pin), .sample_tick(sample_tick),
      .sample_ready_output(sample_ready_output), .sclk(sclk), .cs_n(cs_n),
      .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
   imod_host host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ====
   // Tasks
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Reply to a read comes out in the following frame
   task automatic rd(input logic [7:0] addr, input logic [15:0] exp, input string what);
      logic [15:0] tmp;
      host.xfer({1'h0, addr[6:0], 8'h00}, tmp);
      host.xfer(16'h0000, v);
      check(what, v, exp);
      // Back onto the falling edge so later stimulus never races a rising edge
      @(negedge clk);
   endtask
   task automatic tick(input int n);
      ext_sample_tick = 1'h1;
      repeat (n) @(negedge clk);
      ext_sample_tick = 1'h0;
      repeat (4) @(negedge clk);
   endtask
   task automatic cmd;
      reset_cmd = 1'h1;
      @(negedge clk);
      reset_cmd = 1'h0;
   endtask
   task automatic end_sim;
      if (err_total == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ====
   // Tests
   initial begin
      rst = 1'h1; ext_sample_tick = 1'h0; reset_cmd = 1'h0; sync_pin = 1'h0;
      sync_mode = 3'h0; decimation_setting = 16'h0; temp_sample = 16'hfe70;
      accel_y_sample = 32'h7d000001; accel_z_sample = 32'h8300fffe;
      gyro_x_sample = 32'h00012345; gyro_y_sample = 32'hffff0000;
      gyro_z_sample = 32'h00000001;
      err_total = 0; tests_run = 0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'h0;
      // Internal sample clock runs; stamp unused here
      repeat (100) @(negedge clk);
      rd(`IMOD_OFS_STAMP, 16'h0000, "stamp internal");
      check("oe idle", {15'h0, sdo_oe}, 16'h0);
      sync_mode = 3'h2;
      decimation_setting = 16'h2;
      cmd();
      rd(`IMOD_OFS_COUNTER, 16'h0000, "counter cleared");
      // Two ticks are one short of an update
      tick(2);
      rd(`IMOD_OFS_COUNTER, 16'h0000, "counter early");
      tick(1);
      rd(`IMOD_OFS_COUNTER, 16'h0001, "counter one");
      rd(`IMOD_OFS_ACCEL_Y_HIGH, accel_y_sample[31:16], "ay high");
      rd(`IMOD_OFS_ACCEL_Y_LOW, accel_y_sample[15:0], "ay low");
      rd(`IMOD_OFS_ACCEL_Z_HIGH, accel_z_sample[31:16], "az high");
      rd(`IMOD_OFS_ACCEL_Z_LOW, accel_z_sample[15:0], "az low");
      rd(`IMOD_OFS_TEMP, temp_sample, "temp");
      // Constant rate over three samples integrates to three samples
      da = gyro_x_sample * 32'h3;
      rd(`IMOD_OFS_DANG_X_HIGH, da[31:16], "dx high");
      rd(`IMOD_OFS_DANG_X_LOW, da[15:0], "dx low");
      da = gyro_y_sample * 32'h3;
      rd(`IMOD_OFS_DANG_Y_HIGH, da[31:16], "dy high");
      rd(`IMOD_OFS_DANG_Y_LOW, da[15:0], "dy low");
      da = gyro_z_sample * 32'h3;
      rd(`IMOD_OFS_DANG_Z_HIGH, da[31:16], "dz high");
      rd(`IMOD_OFS_DANG_Z_LOW, da[15:0], "dz low");
      rd(8'h20, 16'h0000, "unmapped");
      host.xfer({1'h1, 7'h22, 8'h55}, v);
      rd(`IMOD_OFS_COUNTER, 16'h0001, "after write");
      // Reset command beats a coincident update
      decimation_setting = 16'h0;
      ext_sample_tick = 1'h1;
      cmd();
      ext_sample_tick = 1'h0;
      rd(`IMOD_OFS_COUNTER, 16'h0000, "cmd wins");
      // Stamp counts from the sync edge to the final sample
      sync_pin = 1'h1;
      repeat (5) @(negedge clk);
      sync_pin = 1'h0;
      repeat (30) @(negedge clk);
      tick(1);
      // Edge accepted 3 cycles after the pin; 32 cycles later at 3 cycles a step
      rd(`IMOD_OFS_STAMP, 16'h000a, "stamp read");
      check("stamp window", {15'h0, v >= 16'h8 && v <= 16'hc}, 16'h1);
      cmd();
      tick(65535);
      rd(`IMOD_OFS_COUNTER, 16'hffff, "counter full");
      tick(1);
      rd(`IMOD_OFS_COUNTER, 16'h0000, "counter wrap");
      // Rate calibration left to host software
      end_sim();
   end
   initial begin
      // Tests take about 70k cycles, mostly the counter wrap
      #850000;
      err_total++;
      end_sim();
   end
endmodule
